/* hdl/clw_watchdog.sv */
`timescale 1ns/100ps
// Summary of operation
// [R1] link_state_out reports 0 offline, 1 initialising, 2 ready for a connection (never under TCP), 3 active.
// [R2] the same watchdog runs whether the port carries RTU or TCP traffic.
// [R3] the flag rises once no addressed message has been seen for the configured timeout.
// [R4] a timeout of zero, the reset value, disables the watchdog so the flag never rises.
// [R5] flag_clear_mode 0 (default) clears by software write, 1 clears on valid traffic.
// [R6] in automatic mode recovery_time sets the window that governs clearing, zero after reset.
// [R7] with recovery_time zero the first valid message clears the flag.
// [R8] with recovery_time nonzero two valid messages inside the window are needed to clear the flag.
// [R9] the flag reads as 0 inactive and 1 active.
// [R10] with the turnaround option set, a fixed delay separates frame end from transmit start; 0 means none.
// [R11] time_resolution_select picks ms, s, min or h for scaled time values, ms by default.
// [R12] each addressed message restarts the idle counter, which advances on a fixed time-base tick.
// [R13] in manual mode software clears the flag by writing zero, ignored while the timeout persists.
module clw_watchdog #(
  parameter int TICK_CYCLES = clw_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // port side
  input wire logic port_enable_in,
  input wire logic init_done_in,
  input wire logic tcp_mode_in,
  input wire logic msg_valid_in,
  input wire logic rx_end_in,
  output logic tx_start_out,
  output logic flag_out,
  output logic [1:0] link_state_out,
  output logic [1:0] time_resolution_out,
  output logic irq_out
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int TURN_CYCLES = clw_pkg::TURN_DELAY_CYCLES;

  typedef struct packed {
    clw_pkg::clw_clear_mode_t cfg_mode;
    logic cfg_turn;
    clw_pkg::clw_time_res_t cfg_tres;
    logic [clw_pkg::TIME_W-1:0] timeout;
    logic [clw_pkg::TIME_W-1:0] recovery;
    logic [clw_pkg::IRQ_W-1:0] irq_sts;
    logic [clw_pkg::IRQ_W-1:0] irq_mask;
    logic [TW-1:0] tick_cnt;
    logic [clw_pkg::TIME_W-1:0] idle_cnt;
    logic flag;
    logic rec_active;
    logic [clw_pkg::TIME_W-1:0] rec_cnt;
    logic heard;
    logic turn_busy;
    logic [clw_pkg::TURN_W-1:0] turn_cnt;
    logic tx_start;
    clw_pkg::clw_link_state_t link_state;
    logic irq;
    logic wait_req;
    logic [31:0] rdata;
  } clw_state_t;

  clw_state_t s_r;
  clw_state_t s_nxt;
  logic tick;
  logic wr_acc;
  logic timeout_hold;
  logic set_evt;
  logic auto_clr;
  logic sw_clr;
  logic [31:0] wmerge;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // merge write data into an old word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    tick = 1'b0;
    auto_clr = 1'b0;
    sw_clr = 1'b0;
    wmerge = 32'h0000_0000;
    // a write lands only on the edge that completes the handshake, never on the wait edge
    wr_acc = avs_write_in && !s_r.wait_req;

    // time base: one enable pulse per tick period
    if (s_r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + TW'(1);
    end

    // idle counter saturates so a long silence cannot wrap back under the timeout
    if (msg_valid_in) begin
      s_nxt.idle_cnt = '0; // R12 R2
    end else if (tick && s_r.idle_cnt != 16'hFFFF) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 16'h0001; // R12
    end

    timeout_hold = (s_r.timeout != 16'h0000) && (s_r.idle_cnt >= s_r.timeout); // R3 R4
    set_evt = timeout_hold && !s_r.flag; // R3

    // recovery window: ticks elapsed since the first message after the flag rose
    // limitation: the window is tick-granular, so it closes between N-1 and N ticks after the first message
    if (s_r.rec_active && tick) begin
      if (s_r.rec_cnt + 16'h0001 >= s_r.recovery) begin
        s_nxt.rec_active = 1'b0; // R8
      end else begin
        s_nxt.rec_cnt = s_r.rec_cnt + 16'h0001; // R6
      end
    end
    if (s_r.cfg_mode == clw_pkg::clear_auto && s_r.flag && msg_valid_in) begin
      if (s_r.recovery == 16'h0000) begin
        auto_clr = 1'b1; // R7
      end else if (!s_r.rec_active) begin
        s_nxt.rec_active = 1'b1; // R8
        s_nxt.rec_cnt = '0;
      end else begin
        auto_clr = 1'b1; // R8
        s_nxt.rec_active = 1'b0;
      end
    end
    if (!s_r.flag) begin
      s_nxt.rec_active = 1'b0;
    end

    // bus handshake: one wait cycle, then the request completes
    if ((avs_read_in || avs_write_in) && s_r.wait_req) begin
      s_nxt.wait_req = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      if (avs_read_in) begin
        case (avs_address_in)
          clw_pkg::ADDR_CONFIG: begin
            s_nxt.rdata[clw_pkg::CFG_MODE_BIT] = s_r.cfg_mode;
            s_nxt.rdata[clw_pkg::CFG_TURN_BIT] = s_r.cfg_turn;
            s_nxt.rdata[clw_pkg::CFG_TRES_LSB +: 2] = s_r.cfg_tres;
          end
          clw_pkg::ADDR_TIMEOUT: s_nxt.rdata[15:0] = s_r.timeout;
          clw_pkg::ADDR_RECOVERY: s_nxt.rdata[15:0] = s_r.recovery;
          clw_pkg::ADDR_STATUS: begin
            s_nxt.rdata[clw_pkg::STS_LINK_LSB +: 2] = s_r.link_state; // R1
            s_nxt.rdata[clw_pkg::STS_FLAG_BIT] = s_r.flag; // R9
            s_nxt.rdata[clw_pkg::STS_HOLD_BIT] = timeout_hold;
          end
          clw_pkg::ADDR_IRQ_STATUS: s_nxt.rdata[clw_pkg::IRQ_W-1:0] = s_r.irq_sts;
          clw_pkg::ADDR_IRQ_MASK: s_nxt.rdata[clw_pkg::IRQ_W-1:0] = s_r.irq_mask;
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      s_nxt.wait_req = 1'b1;
    end

    // register writes take effect on the completing edge only
    s_nxt.irq_sts = s_r.irq_sts;
    if (wr_acc) begin
      case (avs_address_in)
        clw_pkg::ADDR_CONFIG: begin
          wmerge = be_merge({28'h0000000, s_r.cfg_tres, s_r.cfg_turn, s_r.cfg_mode},
                            avs_writedata_in, avs_byteenable_in);
          s_nxt.cfg_mode = clw_pkg::clw_clear_mode_t'(wmerge[clw_pkg::CFG_MODE_BIT]); // R5
          s_nxt.cfg_turn = wmerge[clw_pkg::CFG_TURN_BIT]; // R10
          s_nxt.cfg_tres = clw_pkg::clw_time_res_t'(wmerge[clw_pkg::CFG_TRES_LSB +: 2]); // R11
        end
        clw_pkg::ADDR_TIMEOUT: begin
          wmerge = be_merge({16'h0000, s_r.timeout}, avs_writedata_in, avs_byteenable_in);
          s_nxt.timeout = wmerge[15:0]; // R4
        end
        clw_pkg::ADDR_RECOVERY: begin
          wmerge = be_merge({16'h0000, s_r.recovery}, avs_writedata_in, avs_byteenable_in);
          s_nxt.recovery = wmerge[15:0]; // R6
        end
        clw_pkg::ADDR_STATUS: begin
          // a zero written to the flag clears it only in manual mode and once traffic is back
          if (avs_byteenable_in[0] && !avs_writedata_in[clw_pkg::STS_FLAG_BIT] &&
              s_r.cfg_mode == clw_pkg::clear_manual && !timeout_hold) begin
            sw_clr = 1'b1; // R5 R13
          end
        end
        clw_pkg::ADDR_IRQ_STATUS: begin
          if (avs_byteenable_in[0]) begin
            s_nxt.irq_sts = s_r.irq_sts & ~avs_writedata_in[clw_pkg::IRQ_W-1:0];
          end
        end
        clw_pkg::ADDR_IRQ_MASK: begin
          wmerge = be_merge({29'h0000000, s_r.irq_mask}, avs_writedata_in, avs_byteenable_in);
          s_nxt.irq_mask = wmerge[clw_pkg::IRQ_W-1:0];
        end
        default: s_nxt.irq_sts = s_r.irq_sts;
      endcase
    end

    // flag: a rising timeout beats any clear in the same cycle
    s_nxt.flag = (s_r.flag && !(auto_clr || sw_clr)) || set_evt; // R3 R9

    // sticky events, set wins over a one-written clear
    s_nxt.irq_sts[clw_pkg::IRQ_FLAG_SET] = s_nxt.irq_sts[clw_pkg::IRQ_FLAG_SET] | set_evt;
    s_nxt.irq_sts[clw_pkg::IRQ_FLAG_CLR] = s_nxt.irq_sts[clw_pkg::IRQ_FLAG_CLR] | (s_r.flag && !s_nxt.flag);
    s_nxt.irq_sts[clw_pkg::IRQ_MSG] = s_nxt.irq_sts[clw_pkg::IRQ_MSG] | msg_valid_in;
    s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_mask);

    // turnaround: a frame end during a running delay is ignored
    // the delay is a fixed clock count, so it does not scale with the tick parameter
    s_nxt.tx_start = 1'b0;
    if (s_r.turn_busy) begin
      if (s_r.turn_cnt == clw_pkg::TURN_W'(TURN_CYCLES - 1)) begin
        s_nxt.turn_busy = 1'b0;
        s_nxt.tx_start = 1'b1; // R10
      end else begin
        s_nxt.turn_cnt = s_r.turn_cnt + clw_pkg::TURN_W'(1);
      end
    end else if (rx_end_in) begin
      if (s_r.cfg_turn) begin
        s_nxt.turn_busy = 1'b1; // R10
        s_nxt.turn_cnt = '0;
      end else begin
        s_nxt.tx_start = 1'b1; // R10
      end
    end

    // link state; tcp has no listening phase
    // heard drops whenever the port leaves service, so a restarted rtu port listens again
    if (msg_valid_in) begin
      s_nxt.heard = 1'b1;
    end
    if (!port_enable_in) begin
      s_nxt.link_state = clw_pkg::state_offline; // R1
      s_nxt.heard = 1'b0;
    end else if (!init_done_in) begin
      s_nxt.link_state = clw_pkg::state_init; // R1
      s_nxt.heard = 1'b0;
    end else if (tcp_mode_in || s_r.heard) begin
      s_nxt.link_state = clw_pkg::state_active; // R1 R2
    end else begin
      s_nxt.link_state = clw_pkg::state_listening; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // fields with a package reset value or a nonzero one are set after the blanket clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.timeout <= clw_pkg::TIMEOUT_RST;
      s_r.recovery <= clw_pkg::RECOVERY_RST;
      s_r.irq_mask <= clw_pkg::IRQ_MASK_RST;
      s_r.wait_req <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = s_r.wait_req;
  assign tx_start_out = s_r.tx_start;
  assign flag_out = s_r.flag;
  assign link_state_out = s_r.link_state;
  assign time_resolution_out = s_r.cfg_tres;
  assign irq_out = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_frame_end_delayed;
    rx_end_in && s_r.cfg_turn && !s_r.turn_busy;
  endsequence
  sequence seq_quiet_two;
    !tx_start_out ##1 !tx_start_out;
  endsequence
  sequence seq_first_recovery_msg;
    s_r.cfg_mode == clw_pkg::clear_auto && s_r.recovery != 16'h0000 && flag_out && msg_valid_in &&
      !s_r.rec_active;
  endsequence

  chk_link_offline: assert property (!port_enable_in |=> link_state_out == 2'h0) // R1
    else $error("link state not offline while port disabled");
  chk_tcp_no_listen: assert property (tcp_mode_in && port_enable_in && init_done_in |=> link_state_out == 2'h3) // R1
    else $error("tcp port reported a state other than active");
  // a message in auto mode may clear a standing flag, so only the rise itself is checked here
  chk_flag_rise: assert property ( // R3
    !flag_out && s_r.timeout != 16'h0000 && s_r.idle_cnt >= s_r.timeout |=> flag_out)
    else $error("flag did not rise after timeout");
  chk_zero_disable: assert property (s_r.timeout == 16'h0000 && !flag_out |=> !flag_out) // R4
    else $error("flag rose with watchdog disabled");
  chk_manual_hold: assert property (s_r.cfg_mode == clw_pkg::clear_manual && flag_out && !wr_acc |=> flag_out) // R5
    else $error("manual flag cleared without a write");
  chk_auto_first: assert property ( // R7
    s_r.cfg_mode == clw_pkg::clear_auto && s_r.recovery == 16'h0000 && flag_out && msg_valid_in && !set_evt
    |=> !flag_out)
    else $error("first message did not clear flag");
  chk_auto_two_msgs: assert property (seq_first_recovery_msg |=> flag_out ##0 s_r.rec_active) // R8
    else $error("single message cleared flag with recovery set");
  chk_turn_delay: assert property (seq_frame_end_delayed |=> seq_quiet_two) // R10
    else $error("transmit started without turnaround delay");
  chk_turn_none: assert property ( // R10
    rx_end_in && !s_r.cfg_turn && !s_r.turn_busy |=> tx_start_out ##1 !tx_start_out)
    else $error("transmit start missing without delay");
  chk_tres_write: assert property ( // R11
    wr_acc && avs_address_in == clw_pkg::ADDR_CONFIG && avs_byteenable_in[0]
    |=> time_resolution_out == $past(avs_writedata_in[3:2]))
    else $error("time resolution did not follow write");
  chk_idle_restart: assert property (msg_valid_in |=> s_r.idle_cnt == 16'h0000) // R12
    else $error("idle counter not restarted by message");
  // auto mode clears on traffic even while the idle count is high, so the block applies to manual mode only
  chk_sw_blocked: assert property ( // R13
    s_r.cfg_mode == clw_pkg::clear_manual && flag_out && timeout_hold && !set_evt |=> flag_out)
    else $error("flag cleared while timeout persists");
  chk_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus request not answered in one cycle");

  // further guards on link state, bus timing, the recovery window and sticky events
  chk_link_init: assert property (port_enable_in && !init_done_in |=> link_state_out == 2'h1) // R1
    else $error("link state not initialising before init done");
  chk_rtu_listen: assert property ( // R1
    port_enable_in && init_done_in && !tcp_mode_in && !s_r.heard && !msg_valid_in |=> link_state_out == 2'h2)
    else $error("rtu port not listening before first message");
  chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  // an expired window must be reopened by a fresh first message
  chk_window_close: assert property ( // R8
    s_r.rec_active && tick && s_r.rec_cnt + 16'h0001 >= s_r.recovery |=> !s_r.rec_active)
    else $error("recovery window did not close on expiry");
  chk_rise_event: assert property (set_evt |=> s_r.irq_sts[clw_pkg::IRQ_FLAG_SET]) // R3
    else $error("flag rise not recorded as an event");

endmodule : clw_watchdog

/* hdl/clw_pkg.sv */
package clw_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TURN_DELAY_NS = 200000;
  localparam int TURN_DELAY_CYCLES = (TURN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_W = 11;

  // register byte offsets
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_TIMEOUT = 5'h04;
  localparam logic [4:0] ADDR_RECOVERY = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;

  // field positions
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_TURN_BIT = 1;
  localparam int CFG_TRES_LSB = 2;
  localparam int STS_LINK_LSB = 0;
  localparam int STS_FLAG_BIT = 2;
  localparam int STS_HOLD_BIT = 3;
  localparam int IRQ_FLAG_SET = 0;
  localparam int IRQ_FLAG_CLR = 1;
  localparam int IRQ_MSG = 2;
  localparam int IRQ_W = 3;
  localparam int TIME_W = 16;

  // reset values
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam logic [15:0] RECOVERY_RST = 16'h0000;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [1:0] {state_offline, state_init, state_listening, state_active} clw_link_state_t;
  typedef enum logic {clear_manual, clear_auto} clw_clear_mode_t;
  typedef enum logic [1:0] {res_msec, res_sec, res_min, res_hour} clw_time_res_t;
endpackage : clw_pkg

/* test/clw_master_model.sv */
`timescale 1ns/100ps
module clw_master_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic poll_in,
  input wire logic [3:0] gap_in,
  output logic msg_valid_out,
  output logic rx_end_out
);
  logic busy_r;
  logic [3:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // one addressed request per poll; gap_in lets the master answer late to stress the recovery window
  always_ff @(posedge clk_in) begin
    msg_valid_out <= 1'h0;
    rx_end_out <= 1'h0;
    if (rst_in) begin
      busy_r <= 1'h0;
      cnt_r <= 4'h0;
    end else if (busy_r) begin
      if (cnt_r == 4'h0) begin
        msg_valid_out <= 1'h1;
        rx_end_out <= 1'h1;
        busy_r <= 1'h0;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end else if (poll_in) begin
      busy_r <= 1'h1;
      cnt_r <= gap_in;
    end
  end
endmodule : clw_master_model

/* test/clw_watchdog_tb_top.sv */
`timescale 1ns/100ps
module clw_watchdog_tb_top;
  logic clk_in, rst_in, rd, wr, poll, port_en, init_done, tcp;
  logic [4:0] addr;
  logic [31:0] wdata, rd_data, rdata_w;
  logic [3:0] gap;
  logic wait_w, msg_w, rx_end_w, tx_w, flag_w, irq_w;
  logic [1:0] link_w, tres_w;
  int n_fail, num_checks, lat;
  ////////////////////////////////////////////////////////////////////////////////
  // short tick keeps timeouts to tens of cycles
  clw_watchdog #(.TICK_CYCLES(10)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata_w), .avs_waitrequest_out(wait_w), .port_enable_in(port_en),
    .init_done_in(init_done), .tcp_mode_in(tcp), .msg_valid_in(msg_w), .rx_end_in(rx_end_w),
    .tx_start_out(tx_w), .flag_out(flag_w), .link_state_out(link_w), .time_resolution_out(tres_w),
    .irq_out(irq_w));
  clw_master_model u_master (.clk_in(clk_in), .rst_in(rst_in), .poll_in(poll), .gap_in(gap),
    .msg_valid_out(msg_w), .rx_end_out(rx_end_w));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // the request is held until waitrequest is seen low, then released on the next rising edge
  task bus(input logic is_rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd <= is_rd;
    wr <= !is_rd;
    do begin @(negedge clk_in); n++; end while (wait_w !== 1'h0 && n < 50);
    chk("waitrequest", 32'h0, {31'h0, wait_w});
    rd_data = rdata_w;
    @(posedge clk_in);
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus
  task rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
    bus(1'h1, a, 32'h0);
    chk(name, exp, rd_data);
  endtask : rd_chk
  // lat counts cycles from frame end to transmit start
  task do_poll(input logic [3:0] g);
    int n;
    n = 0;
    @(posedge clk_in);
    poll <= 1'h1;
    gap <= g;
    @(posedge clk_in);
    poll <= 1'h0;
    do begin @(negedge clk_in); n++; end while (rx_end_w !== 1'h1 && n < 40);
    lat = 0;
    do begin @(negedge clk_in); lat++; end while (tx_w !== 1'h1 && lat < 3000);
  endtask : do_poll
  task wait_flag(input logic exp, input int lim);
    int n;
    n = 0;
    while (flag_w !== exp && n < lim) begin @(negedge clk_in); n++; end
    chk("flag", {31'h0, exp}, {31'h0, flag_w});
  endtask : wait_flag
  task settle();
    repeat (3) @(negedge clk_in);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset();
    rd_chk("config", clw_pkg::ADDR_CONFIG, 32'h0);
    rd_chk("timeout", clw_pkg::ADDR_TIMEOUT, 32'h0);
    rd_chk("recovery", clw_pkg::ADDR_RECOVERY, 32'h0);
    rd_chk("irq_mask", clw_pkg::ADDR_IRQ_MASK, 32'h0);
    rd_chk("status", clw_pkg::ADDR_STATUS, 32'h0);
    bus(1'h0, 5'h18, 32'h0000000F);
    rd_chk("unmapped", 5'h18, 32'h0);
  endtask : t_reset
  task t_link();
    @(posedge clk_in);
    port_en <= 1'h1;
    settle();
    chk("link_init", 32'h1, {30'h0, link_w});
    @(posedge clk_in);
    init_done <= 1'h1;
    settle();
    chk("link_listen", 32'h2, {30'h0, link_w});
    do_poll(4'h0);
    chk("no_delay", 32'h1, lat);
    settle();
    chk("link_active", 32'h3, {30'h0, link_w});
    @(posedge clk_in);
    port_en <= 1'h0;
    settle();
    chk("link_off", 32'h0, {30'h0, link_w});
    @(posedge clk_in);
    port_en <= 1'h1;
    tcp <= 1'h1;
    settle();
    chk("link_tcp", 32'h3, {30'h0, link_w});
  endtask : t_link
  // watchdog runs under tcp here; zero timeout must never raise the flag
  task t_manual();
    repeat (100) @(negedge clk_in);
    chk("flag_disabled", 32'h0, {31'h0, flag_w});
    bus(1'h0, clw_pkg::ADDR_IRQ_STATUS, 32'h7);
    bus(1'h0, clw_pkg::ADDR_TIMEOUT, 32'h3);
    wait_flag(1'h1, 60);
    rd_chk("status_flag", clw_pkg::ADDR_STATUS, 32'hF);
    rd_chk("irq_status", clw_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq_w});
    bus(1'h0, clw_pkg::ADDR_IRQ_MASK, 32'h1);
    settle();
    chk("irq_on", 32'h1, {31'h0, irq_w});
    bus(1'h0, clw_pkg::ADDR_STATUS, 32'h0);
    wait_flag(1'h1, 3);
    do_poll(4'h0);
    bus(1'h0, clw_pkg::ADDR_STATUS, 32'h0);
    wait_flag(1'h0, 3);
    bus(1'h0, clw_pkg::ADDR_IRQ_STATUS, 32'h7);
    settle();
    chk("irq_off", 32'h0, {31'h0, irq_w});
  endtask : t_manual
  task t_auto();
    @(posedge clk_in);
    tcp <= 1'h0;
    bus(1'h0, clw_pkg::ADDR_CONFIG, 32'h1);
    wait_flag(1'h1, 60);
    do_poll(4'h0);
    wait_flag(1'h0, 3);
  endtask : t_auto
  // window of five ticks: one message is not enough, a late second one inside it clears
  task t_recover();
    bus(1'h0, clw_pkg::ADDR_RECOVERY, 32'h5);
    rd_chk("recovery_rb", clw_pkg::ADDR_RECOVERY, 32'h5);
    wait_flag(1'h1, 60);
    do_poll(4'h0);
    settle();
    chk("flag_one_msg", 32'h1, {31'h0, flag_w});
    do_poll(4'h3);
    wait_flag(1'h0, 3);
  endtask : t_recover
  task t_turn();
    bus(1'h0, clw_pkg::ADDR_CONFIG, 32'h2);
    do_poll(4'h0);
    chk("turn_delay", clw_pkg::TURN_DELAY_CYCLES + 1, lat);
    bus(1'h0, clw_pkg::ADDR_CONFIG, 32'h0);
    do_poll(4'h1);
    chk("turn_none", 32'h1, lat);
  endtask : t_turn
  task t_tres();
    for (int r = 0; r < 4; r++) begin
      bus(1'h0, clw_pkg::ADDR_CONFIG, r << 2);
      settle();
      chk("time_res", r, {30'h0, tres_w});
      rd_chk("config_tres", clw_pkg::ADDR_CONFIG, r << 2);
    end
  endtask : t_tres
  ////////////////////////////////////////////////////////////////////////////////
  // free running clock at 10 MHz
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  // the whole sequence takes well under 10000 cycles
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {rst_in, rd, wr, poll, port_en, init_done, tcp} = 7'h40;
    addr = 5'h0;
    wdata = 32'h0;
    gap = 4'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    t_reset();
    t_link();
    t_manual();
    t_auto();
    t_recover();
    t_turn();
    t_tres();
    wrap_up();
  end
endmodule : clw_watchdog_tb_top
